// ===== rtl/mppm_pkg.sv
// constants and types for the memory and logic-array power manager
package mppm_pkg;
   // power mode register first: bit positions
   localparam int unsigned FULL_SPEED_OFF_BIT = 3;
   localparam int unsigned CLK_BLOCK_AND_BIT = 4;
   localparam int unsigned CLK_BLOCK_MCELL_BIT = 5;
   // power mode register third: bit positions for input blocking
   localparam int unsigned BLK_ADDR_BIT = 0;
   localparam int unsigned BLK_CNTL0_BIT = 2;
   localparam int unsigned BLK_CNTL1_BIT = 3;
   localparam int unsigned BLK_CNTL2_BIT = 4;
   localparam int unsigned BLK_STROBE_BIT = 5;
   localparam int unsigned BLK_DBE_BIT = 6;
   // reset values of the two mode registers
   localparam logic [7:0] PMR_FIRST_RESET = 8'h00;
   localparam logic [7:0] PMR_THIRD_RESET = 8'h00;
   // idle counter: four bits, power-down after fifteen idle clock periods
   localparam logic [3:0] IDLE_LIMIT = 4'hF;
   localparam logic [3:0] IDLE_ZERO = 4'h0;
   localparam logic [3:0] IDLE_ONE = 4'h1;
   // auto power-down states
   typedef enum logic [0:0] {
      MPPM_RUN = 1'b0,
      MPPM_DOWN = 1'b1
   } mppm_state_t;
endpackage

// ===== rtl/mppm_power_manager.sv
// power manager for flash, sram and logic arrays of a host-bus peripheral
//
// Summary of operation
// - memories idle to standby on steady inputs
// - enabled unit watches strobe, powers down idle
// - power-down holds host address and data, deselects memories
// - unblocked toggling inputs keep arrays active
// - chip select low active; high disables memories
// - chip select deselect only idles the memories
// - host writes blocking bits gating array inputs
// - image blocks unused address or control inputs
// - full-speed bit resets on; set turns off
// - speed off: arrays standby on steady inputs
// - clock pin drives macrocells and idle counter
// - strobe pin is the monitored address strobe
// - fifteen idle clock periods raise power-down flag
// - strobe, chip select falling edge, reset exit power-down
// - full-speed control lives at bit three
// - bits four, five block clock to arrays
`timescale 1ns/1ps
module mppm_power_manager (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic reset_in,
   // dedicated pins, asynchronous
   input wire logic strobe_pin,
   input wire logic logic_clock_in,
   input wire logic chip_sel_b_pin,
   input wire logic data_bus_enable_in,
   // configuration image
   input wire logic cfg_strobe_dedicated,
   input wire logic cfg_clock_dedicated,
   input wire logic cfg_cs_dedicated,
   input wire logic cfg_addr_used,
   input wire logic cfg_ctrl_used,
   input wire logic auto_pd_enable,
   // host register writes, same clock
   input wire logic pmr_first_we,
   input wire logic pmr_third_we,
   input wire logic [7:0] pmr_wdata,
   // host bus, same clock
   input wire logic [7:0] low_address_byte,
   input wire logic [7:0] host_data,
   input wire logic [2:0] host_control_inputs,
   // memory side
   output logic [7:0] mem_address,
   output logic [7:0] mem_data,
   output logic mem_select,
   output logic mem_standby,
   output logic io_block_enable,
   // logic-array side
   output logic [7:0] array_address,
   output logic [7:0] array_data,
   output logic [2:0] array_control,
   output logic array_strobe,
   output logic array_dbe,
   output logic array_clk_and,
   output logic array_clk_mcell,
   output logic array_standby,
   output logic array_full_speed,
   // status
   output logic power_down_flag,
   output logic [7:0] power_mode_reg_first,
   output logic [7:0] power_mode_reg_third
);
   // synchronisers: stage one is read only by stage two
   logic [3:0] sync_a;
   logic [3:0] sync_b;
   logic [3:0] pins_in;
   logic strobe_prev; // last strobe sample for edge detect
   logic clk_prev; // last clock-pin sample
   logic cs_prev; // last chip select sample, same reset as its synchroniser so no false edge
   assign pins_in = {data_bus_enable_in, chip_sel_b_pin, logic_clock_in, strobe_pin};
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
         strobe_prev <= 1'b0;
         clk_prev <= 1'b0;
         cs_prev <= 1'b0;
      end else begin
         sync_a <= pins_in;
         sync_b <= sync_a;
         strobe_prev <= sync_b[0];
         clk_prev <= sync_b[1];
         cs_prev <= sync_b[2];
      end
   end
   // decoded pin functions
   logic strobe_s, clk_s, cs_b_s, dbe_s, strobe_edge, clk_rise, cs_active, cs_fall;
   assign strobe_s = cfg_strobe_dedicated & sync_b[0];
   assign clk_s = cfg_clock_dedicated & sync_b[1];
   assign cs_b_s = sync_b[2];
   assign dbe_s = sync_b[3];
   assign strobe_edge = cfg_strobe_dedicated & (sync_b[0] ^ strobe_prev);
   // clock-pin period counted on its rising edge; blocking bits not involved
   assign clk_rise = cfg_clock_dedicated & sync_b[1] & ~clk_prev;
   // unused chip select reads as selected
   assign cs_active = ~cfg_cs_dedicated | ~cs_b_s;
   // wake on the falling edge only: a chip select held low would keep the idle counter cleared
   assign cs_fall = cfg_cs_dedicated & cs_prev & ~cs_b_s;

   // power mode registers, host-writable at run time
   logic [7:0] next_pmr_first, next_pmr_third;
   always_comb begin
      next_pmr_first = power_mode_reg_first;
      next_pmr_third = power_mode_reg_third;
      if (pmr_first_we) next_pmr_first = pmr_wdata;
      if (pmr_third_we) next_pmr_third = pmr_wdata;
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         power_mode_reg_first <= mppm_pkg::PMR_FIRST_RESET; // full speed on
         power_mode_reg_third <= mppm_pkg::PMR_THIRD_RESET;
      end else begin
         power_mode_reg_first <= next_pmr_first;
         power_mode_reg_third <= next_pmr_third;
      end
   end

   // auto power-down unit: idle counter and state
   mppm_pkg::mppm_state_t state, next_state;
   logic [3:0] idle_cnt, next_idle_cnt;
   logic wake;
   // wake on strobe activity, chip select falling edge, or reset input high
   assign wake = strobe_edge | cs_fall | reset_in;
   always_comb begin
      next_state = state;
      next_idle_cnt = idle_cnt;
      case (state)
         mppm_pkg::MPPM_RUN: begin
            if (!auto_pd_enable || strobe_edge) begin
               next_idle_cnt = mppm_pkg::IDLE_ZERO;
            end else if (clk_rise) begin
               if (idle_cnt == mppm_pkg::IDLE_LIMIT - mppm_pkg::IDLE_ONE) begin
                  // fifteenth idle period: enter power-down
                  next_idle_cnt = mppm_pkg::IDLE_LIMIT;
                  next_state = mppm_pkg::MPPM_DOWN;
               end else begin
                  next_idle_cnt = idle_cnt + mppm_pkg::IDLE_ONE;
               end
            end
            // a wake condition the same cycle keeps the unit running
            if (wake) begin
               next_state = mppm_pkg::MPPM_RUN;
               if (!strobe_edge) next_idle_cnt = mppm_pkg::IDLE_ZERO;
            end
         end
         mppm_pkg::MPPM_DOWN: begin
            if (wake || !auto_pd_enable) begin
               next_state = mppm_pkg::MPPM_RUN;
               next_idle_cnt = mppm_pkg::IDLE_ZERO;
            end
         end
         default: begin
            next_state = mppm_pkg::MPPM_RUN;
            next_idle_cnt = mppm_pkg::IDLE_ZERO;
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= mppm_pkg::MPPM_RUN;
         idle_cnt <= mppm_pkg::IDLE_ZERO;
      end else begin
         state <= next_state;
         idle_cnt <= next_idle_cnt;
      end
   end

   // gating of memory and array paths
   logic pd, blk_addr, blk_cntl0, blk_cntl1, blk_cntl2, blk_strobe, blk_dbe;
   logic speed_off, blk_clk_and, blk_clk_mcell;
   assign pd = (next_state == mppm_pkg::MPPM_DOWN);
   // image blocks unused inputs; host bits block further
   assign blk_addr = ~cfg_addr_used | power_mode_reg_third[mppm_pkg::BLK_ADDR_BIT];
   assign blk_cntl0 = ~cfg_ctrl_used | power_mode_reg_third[mppm_pkg::BLK_CNTL0_BIT];
   assign blk_cntl1 = ~cfg_ctrl_used | power_mode_reg_third[mppm_pkg::BLK_CNTL1_BIT];
   assign blk_cntl2 = ~cfg_ctrl_used | power_mode_reg_third[mppm_pkg::BLK_CNTL2_BIT];
   assign blk_strobe = ~cfg_ctrl_used | power_mode_reg_third[mppm_pkg::BLK_STROBE_BIT];
   assign blk_dbe = ~cfg_ctrl_used | power_mode_reg_third[mppm_pkg::BLK_DBE_BIT];
   assign speed_off = power_mode_reg_first[mppm_pkg::FULL_SPEED_OFF_BIT];
   assign blk_clk_and = power_mode_reg_first[mppm_pkg::CLK_BLOCK_AND_BIT];
   assign blk_clk_mcell = power_mode_reg_first[mppm_pkg::CLK_BLOCK_MCELL_BIT];

   // held array inputs, to see whether any of them changes
   logic [22:0] next_array_vec, array_vec;
   logic next_mem_select;
   always_comb begin
      next_array_vec[7:0] = (pd | blk_addr) ? array_address : low_address_byte;
      next_array_vec[15:8] = pd ? array_data : host_data;
      next_array_vec[16] = blk_cntl0 ? array_control[0] : host_control_inputs[0];
      next_array_vec[17] = blk_cntl1 ? array_control[1] : host_control_inputs[1];
      next_array_vec[18] = blk_cntl2 ? array_control[2] : host_control_inputs[2];
      next_array_vec[19] = blk_strobe ? array_strobe : strobe_s;
      next_array_vec[20] = blk_dbe ? array_dbe : dbe_s;
      next_array_vec[21] = blk_clk_and ? array_clk_and : clk_s;
      next_array_vec[22] = blk_clk_mcell ? array_clk_mcell : clk_s;
      // chip select only idles memories, arrays untouched
      next_mem_select = cs_active & ~pd;
   end
   assign array_vec = {array_clk_mcell, array_clk_and, array_dbe, array_strobe, array_control,
                       array_data, array_address};
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_address <= 8'h00;
         mem_data <= 8'h00;
         mem_select <= 1'b0;
         mem_standby <= 1'b1;
         io_block_enable <= 1'b0;
         {array_clk_mcell, array_clk_and, array_dbe, array_strobe, array_control,
          array_data, array_address} <= 23'h00_0000;
         array_standby <= 1'b1;
         array_full_speed <= 1'b1;
         power_down_flag <= 1'b0;
      end else begin
         // memories latch only changed, selected inputs; else standby
         if (next_mem_select) begin
            mem_address <= low_address_byte;
            mem_data <= host_data;
         end
         mem_select <= next_mem_select;
         mem_standby <= ~next_mem_select |
                        ((low_address_byte == mem_address) & (host_data == mem_data));
         io_block_enable <= next_mem_select;
         {array_clk_mcell, array_clk_and, array_dbe, array_strobe, array_control,
          array_data, array_address} <= next_array_vec;
         // unblocked changing inputs keep arrays awake; in power-down only control, strobe, dbe and clock inputs, as address and data are held
         array_standby <= speed_off & (next_array_vec == array_vec);
         array_full_speed <= ~speed_off;
         power_down_flag <= pd;
      end
   end

   // checks
   flag_follows_state_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      1'b1 |=> power_down_flag == (state == mppm_pkg::MPPM_DOWN))
      else $error("power-down flag differs from state");
   cs_deselect_mem_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (cfg_cs_dedicated && cs_b_s) |=> !mem_select && mem_standby)
      else $error("memory selected while chip select high");
   pd_blocks_mem_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (state == mppm_pkg::MPPM_DOWN) |-> !mem_select)
      else $error("memory selected during power-down");
   full_speed_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(speed_off) |=> !array_full_speed)
      else $error("full speed stays on after bit set");
   speed_on_awake_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !speed_off |=> !array_standby)
      else $error("arrays in standby at full speed");
   edge_clears_cnt_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (strobe_edge || !auto_pd_enable) |=> idle_cnt == mppm_pkg::IDLE_ZERO)
      else $error("idle counter not cleared");
   wake_exits_pd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (state == mppm_pkg::MPPM_DOWN && reset_in) |=> state == mppm_pkg::MPPM_RUN)
      else $error("reset input did not end power-down");
   cs_fall_wakes_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (state == mppm_pkg::MPPM_DOWN && cs_fall) |=> state == mppm_pkg::MPPM_RUN)
      else $error("chip select edge did not end power-down");
   pd_needs_count_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(state == mppm_pkg::MPPM_DOWN) |->
         $past(idle_cnt) == (mppm_pkg::IDLE_LIMIT - mppm_pkg::IDLE_ONE) && $past(clk_rise))
      else $error("power-down without fifteen idle periods");
   clk_block_and_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (blk_clk_and && $past(blk_clk_and)) |-> $stable(array_clk_and))
      else $error("blocked clock reached and array");
endmodule

// ===== testbench/memory_pld_power_manager_tb.sv
// self-checking bench for the memory and logic-array power manager
`timescale 1ns/1ps
module memory_pld_power_manager_tb;
   logic ref_clk = 0, rst_b = 0, reset_in = 0, logic_clock_in = 0, chip_sel_b_pin = 0, data_bus_enable_in = 0;
   logic auto_pd_enable = 0, cfg_addr_used = 1, cfg_ctrl_used = 1, pmr_first_we = 0, pmr_third_we = 0;
   logic cfg_cs_dedicated = 1; // chip select pin in its dedicated use until the last scenario
   logic strobe_on = 0, bus_on = 0, strobe_pin, mem_select, mem_standby, io_block_enable, array_strobe;
   logic array_dbe, array_clk_and, array_clk_mcell, array_standby, array_full_speed, power_down_flag;
   logic [7:0] pmr_wdata = 0, low_address_byte, host_data, mem_address, mem_data, array_address, array_data;
   logic [7:0] power_mode_reg_first, power_mode_reg_third, snap, snap2, exp_first, exp_third;
   logic [2:0] host_control_inputs = 0, array_control;
   int fail_count = 0, n_compared = 0, cycles = 0, n_rise = 0, i, k;
   int blk_bits[6] = '{0, 2, 3, 4, 5, 6};
   integer seed = 32'h8590;
   mppm_power_manager dut (.ref_clk, .rst_b, .reset_in, .strobe_pin, .logic_clock_in, .chip_sel_b_pin,
      .data_bus_enable_in, .cfg_strobe_dedicated(1'b1), .cfg_clock_dedicated(1'b1), .cfg_cs_dedicated,
      .cfg_addr_used, .cfg_ctrl_used, .auto_pd_enable, .pmr_first_we, .pmr_third_we, .pmr_wdata,
      .low_address_byte, .host_data, .host_control_inputs, .mem_address, .mem_data, .mem_select, .mem_standby,
      .io_block_enable, .array_address, .array_data, .array_control, .array_strobe, .array_dbe, .array_clk_and,
      .array_clk_mcell, .array_standby, .array_full_speed, .power_down_flag, .power_mode_reg_first,
      .power_mode_reg_third);
   mppm_host_model host (.ref_clk, .strobe_on, .bus_on, .strobe_pin, .low_address_byte, .host_data);
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   // hang guard: a whole run needs well under a thousand cycles
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         end_sim();
      end
   end
   // logic clock pin runs at a quarter rate; control noise follows the bus
   always @(negedge ref_clk) begin
      if (cycles % 2 == 0) begin
         logic_clock_in <= ~logic_clock_in;
         if (!logic_clock_in) n_rise++;
      end
      if (bus_on) {data_bus_enable_in, host_control_inputs} <= 4'($random(seed));
   end
   task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // one-cycle write pulse to either mode register
   task wr(input logic third, input logic [7:0] d);
      pmr_first_we = !third;
      pmr_third_we = third;
      pmr_wdata = d;
      cyc(1);
      pmr_first_we = 0;
      pmr_third_we = 0;
   endtask
   task wait_rises(input int n);
      int s;
      s = n_rise;
      while (n_rise - s < n) cyc(1);
   endtask
   // array output that a given third-register bit gates
   function automatic logic [7:0] fld(input int b);
      case (b)
         0: return array_address;
         5: return {7'h00, array_strobe};
         6: return {7'h00, array_dbe};
         default: return {7'h00, array_control[b-2]};
      endcase
   endfunction
   task end_sim();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      cyc(20);
      check("standby in reset", {7'h00, mem_standby}, 8'h01);
      check("full speed in reset", {7'h00, array_full_speed}, 8'h01);
      rst_b = 1;
      cyc(2);
      // speed off plus both clock blocks; idle counter must still run later
      exp_first = 8'h38;
      wr(0, exp_first);
      cyc(1);
      check("reg first", power_mode_reg_first, exp_first);
      check("full speed", {7'h00, array_full_speed}, 8'h00);
      snap = {6'h00, array_clk_mcell, array_clk_and};
      wait_rises(3);
      check("array clocks", {6'h00, array_clk_mcell, array_clk_and}, snap);
      bus_on = 1;
      strobe_on = 1;
      cyc(6);
      bus_on = 0;
      cyc(4);
      check("mem address", mem_address, low_address_byte);
      check("mem data", mem_data, host_data);
      check("array address", array_address, low_address_byte);
      check("array data", array_data, host_data);
      check("mem select", {7'h00, mem_select}, 8'h01);
      // unit disabled: a silent strobe never powers down
      strobe_on = 0;
      bus_on = 1;
      wait_rises(20);
      check("flag disabled", {7'h00, power_down_flag}, 8'h00);
      auto_pd_enable = 1;
      // three ways out of power-down: strobe, chip select low, reset input
      for (k = 0; k < 3; k++) begin
         strobe_on = 1;
         chip_sel_b_pin = (k == 1);
         cyc(6);
         if (k == 1) begin
            check("cs high select", {7'h00, mem_select}, 8'h00);
            check("cs high io", {7'h00, io_block_enable}, 8'h00);
            bus_on = 0;
            cyc(4);
            check("cs high array", array_address, low_address_byte);
            bus_on = 1;
         end
         strobe_on = 0;
         wait_rises(13);
         check("flag early", {7'h00, power_down_flag}, 8'h00);
         wait_rises(4);
         check("flag set", {7'h00, power_down_flag}, 8'h01);
         check("down select", {7'h00, mem_select}, 8'h00);
         check("down standby", {7'h00, mem_standby}, 8'h01);
         snap = mem_address;
         snap2 = array_address;
         cyc(8);
         check("frozen mem", mem_address, snap);
         check("frozen array", array_address, snap2);
         case (k)
            0: strobe_on = 1;
            1: chip_sel_b_pin = 0;
            default: reset_in = 1;
         endcase
         for (i = 0; i < 12 && power_down_flag !== 1'b0; i++) cyc(1);
         check("wake flag", {7'h00, power_down_flag}, 8'h00);
         reset_in = 0;
      end
      // each blocking bit freezes its array input while the bus keeps moving
      auto_pd_enable = 0;
      strobe_on = 1;
      bus_on = 1;
      for (i = 0; i < 6; i++) begin
         exp_third = 8'h01 << blk_bits[i];
         wr(1, exp_third);
         cyc(2);
         check("reg third", power_mode_reg_third, exp_third);
         snap = fld(blk_bits[i]);
         cyc(8);
         check("blocked input", fld(blk_bits[i]), snap);
      end
      wr(1, 8'h00);
      cfg_addr_used = 0;
      cyc(3);
      snap = array_address;
      cyc(8);
      check("image address", array_address, snap);
      cfg_addr_used = 1;
      cfg_ctrl_used = 0;
      cyc(3);
      snap = {5'h00, array_control};
      cyc(8);
      check("image control", {5'h00, array_control}, snap);
      // speed off with the bus moving: arrays and memories stay awake
      cyc(2);
      check("array awake", {7'h00, array_standby}, 8'h00);
      check("mem awake", {7'h00, mem_standby}, 8'h00);
      // quiet bus, controls blocked by the image, clocks by the bits: all idle
      bus_on = 0;
      strobe_on = 0;
      cyc(6);
      check("array idle", {7'h00, array_standby}, 8'h01);
      check("mem idle", {7'h00, mem_standby}, 8'h01);
      // full speed back on: arrays never idle, clocks still blocked
      wr(0, 8'h30);
      cyc(2);
      check("array full power", {7'h00, array_standby}, 8'h00);
      check("full speed on", {7'h00, array_full_speed}, 8'h01);
      // chip select pin in general use reads as selected even when high
      cfg_cs_dedicated = 0;
      chip_sel_b_pin = 1;
      cyc(4);
      check("cs unused", {7'h00, mem_select}, 8'h01);
      end_sim();
   end
endmodule

// ===== testbench/mppm_host_model.sv
// host bus model: address strobe plus address and data lines
`timescale 1ns/1ps
module mppm_host_model (
   // clock and controls from the bench
   input wire logic ref_clk,
   input wire logic strobe_on,
   input wire logic bus_on,
   // host bus pins
   output logic strobe_pin,
   output logic [7:0] low_address_byte,
   output logic [7:0] host_data
);
   integer seed = 32'h8590; // fixed seed keeps runs repeatable
   initial begin
      strobe_pin = 1'b0;
      low_address_byte = 8'h00;
      host_data = 8'h00;
   end
   // changes only after the falling edge, well clear of the sampling edge
   always @(negedge ref_clk) begin
      if (strobe_on) begin
         strobe_pin <= ~strobe_pin; // strobe activity seen by the device
      end
      // a quiet host still leaves noise on the bus from other devices
      if (bus_on) begin
         low_address_byte <= $random(seed);
         host_data <= $random(seed);
      end
   end
endmodule
